/* File: hw/mpb_bank_ctrl.sv */
// Bank control: port arbitration, address map, parity and cycle timing
`timescale 1ns/100ps
`default_nettype none
module mpb_bank_ctrl #(
    parameter int BANK_WORDS = mpb_pkg::SMALL_BANK_WORDS,
    parameter logic [15:0] BANK_ID = 16'h0000,
    parameter int NUM_PORTS = mpb_pkg::NUM_PORTS
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [NUM_PORTS-1:0] portReqValid,
    input wire mpb_pkg::mpb_req_type [NUM_PORTS-1:0] portReq,
    output logic [NUM_PORTS-1:0] portAck,
    output logic [NUM_PORTS-1:0] portRspValid,
    output mpb_pkg::mpb_rsp_type portRsp,
    input wire logic idxPresent,
    input wire logic rafPresent,
    input wire logic [mpb_pkg::EXT_LINES_W-1:0] extLinesInstalled,
    output logic hwRegStrobe,
    output logic hwRegWrite,
    output logic [4:0] hwRegAddr,
    output logic [1:0] hwRegHalfEn,
    output logic [31:0] hwRegWdata,
    input wire logic [31:0] hwRegRdata,
    input wire logic parityClear,
    output logic parityIndicator,
    output logic parityIrq,
    output logic bankBusy
);

    localparam int BANK_AW = $clog2(BANK_WORDS);

    mpb_pkg::mpb_state_type state_r;
    mpb_pkg::mpb_state_type state_nxt;
    logic [mpb_pkg::CNT_W-1:0] cnt_r;
    logic [mpb_pkg::CNT_W-1:0] cnt_nxt;
    logic deliver;

    // Latched request of the cycle in progress
    logic [NUM_PORTS-1:0] curPort_r;
    logic curRead_r;
    logic curHigh_r;
    logic curLow_r;
    logic curMark_r;
    logic curHw_r;
    mpb_pkg::mpb_loc_type curClass_r;

    mpb_pkg::mpb_rsp_type portRsp_r;
    logic [NUM_PORTS-1:0] portRspValid_r;
    logic parityInd_r;
    logic parityIrq_r;
    logic hwRegStrobe_r;
    logic hwRegWrite_r;
    logic [4:0] hwRegAddr_r;
    logic [1:0] hwRegHalfEn_r;
    logic [31:0] hwRegWdata_r;

    // Bank select per port
    logic [NUM_PORTS-1:0] bankHit;
    logic [NUM_PORTS-1:0] eligible;
    logic [NUM_PORTS-1:0] grant;
    logic grantAny;

    genvar g;
    generate
        for (g = 0; g < NUM_PORTS; g++) begin : gPort
            wire [15:0] bankOfAddr = 16'(portReq[g].addr >> BANK_AW);
            assign bankHit[g] = (bankOfAddr == BANK_ID);
            assign eligible[g] = portReqValid[g] && bankHit[g];
            if (g == 0) begin : gTop
                assign grant[g] = eligible[g];
            end else begin : gLower
                assign grant[g] = eligible[g] && !(|eligible[g-1:0]);
            end
        end
    endgenerate

    // Only one grant, and only between cycles
    assign grantAny = (state_r == mpb_pkg::ST_IDLE) && (|eligible);
    assign portAck = grantAny ? grant : '0;

    mpb_pkg::mpb_req_type selReq;
    always_comb begin
        selReq = '0;
        for (int i = 0; i < NUM_PORTS; i++) begin
            if (grant[i]) begin
                selReq = selReq | portReq[i];
            end
        end
    end

    // Address classification against the reserved map
    wire [15:0] a = selReq.addr;
    wire isAcc = (a == mpb_pkg::ACC_ADDR);
    wire isSave = (a == mpb_pkg::SAVE_ADDR);
    wire isIdx = (a >= mpb_pkg::IDX_FIRST) && (a <= mpb_pkg::IDX_LAST);
    wire isRaf = (a >= mpb_pkg::RAF_FIRST) && (a <= mpb_pkg::RAF_LAST);
    wire isInt = (a >= mpb_pkg::INT_FIRST) && (a <= mpb_pkg::INT_LAST);
    wire isExtRange = (a >= mpb_pkg::EXT_FIRST) && (a <= mpb_pkg::EXT_LAST);
    wire [15:0] extOffset = 16'(a - mpb_pkg::EXT_FIRST);
    wire extInstalled = (extOffset < 16'(extLinesInstalled));
    wire isExt = isExtRange && extInstalled;

    // Absent options fall back to core locations
    wire hwRoute = isAcc || isSave || (isIdx && idxPresent) || (isRaf && rafPresent);

    mpb_pkg::mpb_loc_type selClass;
    assign selClass = hwRoute ? mpb_pkg::LOC_HWREG :
                      isInt ? mpb_pkg::LOC_INTVEC :
                      isExt ? mpb_pkg::LOC_EXTVEC :
                      mpb_pkg::LOC_GENERAL;

    // Marker-only request touches both halves' markers
    wire noHalf = !selReq.xferHigh && !selReq.xferLow;
    wire markHi = selReq.xferMark && (selReq.xferHigh || noHalf);
    wire markLo = selReq.xferMark && (selReq.xferLow || noHalf);

    // Odd parity: data bits plus parity bit carry an odd count of ones
    wire parHiGen = ~^selReq.wdHigh;
    wire parLoGen = ~^selReq.wdLow;

    logic [mpb_pkg::WORD_W-1:0] memWdata;
    logic [mpb_pkg::WORD_W-1:0] memWmask;
    logic [mpb_pkg::WORD_W-1:0] memRdata;

    always_comb begin
        memWdata = '0;
        memWdata[mpb_pkg::LO_DATA_LSB +: mpb_pkg::HALF_W] = selReq.wdLow;
        memWdata[mpb_pkg::LO_MARK_BIT] = selReq.wmark[0];
        memWdata[mpb_pkg::LO_PAR_BIT] = parLoGen;
        memWdata[mpb_pkg::HI_DATA_LSB +: mpb_pkg::HALF_W] = selReq.wdHigh;
        memWdata[mpb_pkg::HI_MARK_BIT] = selReq.wmark[1];
        memWdata[mpb_pkg::HI_PAR_BIT] = parHiGen;
    end

    // Each written half stores its own parity bit
    always_comb begin
        memWmask = '0;
        memWmask[mpb_pkg::LO_DATA_LSB +: mpb_pkg::HALF_W] = {mpb_pkg::HALF_W{selReq.xferLow}};
        memWmask[mpb_pkg::LO_PAR_BIT] = selReq.xferLow;
        memWmask[mpb_pkg::LO_MARK_BIT] = markLo;
        memWmask[mpb_pkg::HI_DATA_LSB +: mpb_pkg::HALF_W] = {mpb_pkg::HALF_W{selReq.xferHigh}};
        memWmask[mpb_pkg::HI_PAR_BIT] = selReq.xferHigh;
        memWmask[mpb_pkg::HI_MARK_BIT] = markHi;
    end

    wire memEn = grantAny && !hwRoute;
    wire memWe = selReq.write;

    mpb_core_mem #(
        .DEPTH(BANK_WORDS),
        .WIDTH(mpb_pkg::WORD_W),
        .AW(BANK_AW)
    ) uMem (
        .sys_clk(sys_clk),
        .en(memEn),
        .addr(selReq.addr[BANK_AW-1:0]),
        .wdata(memWdata),
        .wmask(memWmask),
        .we(memWe),
        .rdata(memRdata)
    );

    // Cycle sequencer: one request per full storage cycle
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        case (state_r)
            mpb_pkg::ST_IDLE: begin
                cnt_nxt = '0;
                if (grantAny) begin
                    state_nxt = mpb_pkg::ST_ACCESS;
                    cnt_nxt = 7'h01;
                end
            end
            mpb_pkg::ST_ACCESS: begin
                cnt_nxt = cnt_r + 7'h01;
                if (cnt_r == mpb_pkg::ACCESS_CYC - 7'h01) begin
                    state_nxt = mpb_pkg::ST_RESTORE;
                end
            end
            mpb_pkg::ST_RESTORE: begin
                cnt_nxt = cnt_r + 7'h01;
                if (cnt_r == mpb_pkg::CYCLE_CYC - 7'h01) begin
                    state_nxt = mpb_pkg::ST_IDLE;
                    cnt_nxt = '0;
                end
            end
            default: begin
                state_nxt = mpb_pkg::ST_IDLE;
                cnt_nxt = '0;
            end
        endcase
    end

    // Read data leave in the cycle that ends the access time
    assign deliver = (state_r == mpb_pkg::ST_ACCESS) && (cnt_r == mpb_pkg::ACCESS_CYC - 7'h01);

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state_r <= mpb_pkg::ST_IDLE;
            cnt_r <= '0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            curPort_r <= '0;
            curRead_r <= 1'b0;
            curHigh_r <= 1'b0;
            curLow_r <= 1'b0;
            curMark_r <= 1'b0;
            curHw_r <= 1'b0;
            curClass_r <= mpb_pkg::LOC_GENERAL;
        end else if (grantAny) begin
            curPort_r <= grant;
            curRead_r <= !selReq.write;
            curHigh_r <= selReq.xferHigh;
            curLow_r <= selReq.xferLow;
            curMark_r <= selReq.xferMark;
            curHw_r <= hwRoute;
            curClass_r <= selClass;
        end
    end

    // Hardware register path for accumulator, save and present options
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            hwRegStrobe_r <= 1'b0;
            hwRegWrite_r <= 1'b0;
            hwRegAddr_r <= '0;
            hwRegHalfEn_r <= '0;
            hwRegWdata_r <= '0;
        end else begin
            hwRegStrobe_r <= grantAny && hwRoute;
            if (grantAny && hwRoute) begin
                hwRegWrite_r <= selReq.write;
                hwRegAddr_r <= selReq.addr[4:0];
                hwRegHalfEn_r <= {selReq.xferHigh, selReq.xferLow};
                hwRegWdata_r <= {selReq.wdHigh, selReq.wdLow};
            end
        end
    end

    // Read return and parity check on the halves actually transferred
    wire [mpb_pkg::HALF_W-1:0] rdHiCore = memRdata[mpb_pkg::HI_DATA_LSB +: mpb_pkg::HALF_W];
    wire [mpb_pkg::HALF_W-1:0] rdLoCore = memRdata[mpb_pkg::LO_DATA_LSB +: mpb_pkg::HALF_W];
    wire parOkHi = ^{memRdata[mpb_pkg::HI_PAR_BIT], rdHiCore};
    wire parOkLo = ^{memRdata[mpb_pkg::LO_PAR_BIT], rdLoCore};
    wire chkHi = curRead_r && !curHw_r && curHigh_r;
    wire chkLo = curRead_r && !curHw_r && curLow_r;
    wire [1:0] parErrNow = {chkHi && !parOkHi, chkLo && !parOkLo};
    wire parFail = deliver && (|parErrNow);

    wire [mpb_pkg::HALF_W-1:0] srcHi = curHw_r ? hwRegRdata[31:16] : rdHiCore;
    wire [mpb_pkg::HALF_W-1:0] srcLo = curHw_r ? hwRegRdata[15:0] : rdLoCore;
    wire [1:0] srcMark = curHw_r ? 2'h0 : {memRdata[mpb_pkg::HI_MARK_BIT], memRdata[mpb_pkg::LO_MARK_BIT]};
    wire noHalfCur = !curHigh_r && !curLow_r;
    wire [1:0] markSel = {curMark_r && (curHigh_r || noHalfCur), curMark_r && (curLow_r || noHalfCur)};

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            portRsp_r <= '0;
            portRspValid_r <= '0;
        end else begin
            portRspValid_r <= deliver ? curPort_r : '0;
            if (deliver) begin
                portRsp_r.rdHigh <= (curRead_r && curHigh_r) ? srcHi : '0;
                portRsp_r.rdLow <= (curRead_r && curLow_r) ? srcLo : '0;
                portRsp_r.rmark <= curRead_r ? (srcMark & markSel) : 2'h0;
                portRsp_r.parErr <= parErrNow;
                portRsp_r.locClass <= curClass_r;
            end
        end
    end

    // Indicator stays lit until cleared; a new failure beats the clear
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            parityInd_r <= 1'b0;
            parityIrq_r <= 1'b0;
        end else begin
            parityIrq_r <= parFail;
            if (parFail) begin
                parityInd_r <= 1'b1;
            end else if (parityClear) begin
                parityInd_r <= 1'b0;
            end
        end
    end

    assign portRsp = portRsp_r;
    assign portRspValid = portRspValid_r;
    assign parityIndicator = parityInd_r;
    assign parityIrq = parityIrq_r;
    assign hwRegStrobe = hwRegStrobe_r;
    assign hwRegWrite = hwRegWrite_r;
    assign hwRegAddr = hwRegAddr_r;
    assign hwRegHalfEn = hwRegHalfEn_r;
    assign hwRegWdata = hwRegWdata_r;
    assign bankBusy = (state_r != mpb_pkg::ST_IDLE);

endmodule
`default_nettype wire

/* File: hw/mpb_pkg.sv */
// Constants and types shared by the multi-port storage bank control
package mpb_pkg;

    localparam int ADDR_W = 16;
    localparam int HALF_W = 16;
    localparam int WORD_W = 36;
    localparam int NUM_PORTS = 4;
    localparam int SMALL_BANK_WORDS = 8192;
    localparam int LARGE_BANK_WORDS = 16384;

    // Stored word layout, low half first
    localparam int LO_DATA_LSB = 0;
    localparam int LO_MARK_BIT = 16;
    localparam int LO_PAR_BIT = 17;
    localparam int HI_DATA_LSB = 18;
    localparam int HI_MARK_BIT = 34;
    localparam int HI_PAR_BIT = 35;

    // Reserved low-address map, octal 0 to 460 written in hex
    localparam logic [15:0] ACC_ADDR = 16'h0000;
    localparam logic [15:0] SAVE_ADDR = 16'h0001;
    localparam logic [15:0] IDX_FIRST = 16'h0002;
    localparam logic [15:0] IDX_LAST = 16'h0007;
    localparam logic [15:0] RAF_FIRST = 16'h0008;
    localparam logic [15:0] RAF_LAST = 16'h0017;
    localparam logic [15:0] INT_FIRST = 16'h0020;
    localparam logic [15:0] INT_LAST = 16'h0030;
    localparam logic [15:0] EXT_FIRST = 16'h0031;
    localparam logic [15:0] EXT_LAST = 16'h0130;
    localparam int EXT_LINES_W = 9;

    // Timing
    localparam int CLK_PERIOD_NS = 25;
    localparam int CYCLE_NS = 2000;
    localparam int ACCESS_NS = 750;
    localparam int CNT_W = 7;
    localparam logic [CNT_W-1:0] CYCLE_CYC = CNT_W'(CYCLE_NS / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] ACCESS_CYC = CNT_W'(ACCESS_NS / CLK_PERIOD_NS);

    typedef enum logic [1:0] {
        LOC_GENERAL = 2'h0,
        LOC_HWREG = 2'h1,
        LOC_INTVEC = 2'h2,
        LOC_EXTVEC = 2'h3
    } mpb_loc_type;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_ACCESS = 2'h1,
        ST_RESTORE = 2'h3
    } mpb_state_type;

    typedef struct packed {
        logic write;
        logic xferHigh;
        logic xferLow;
        logic xferMark;
        logic [ADDR_W-1:0] addr;
        logic [HALF_W-1:0] wdHigh;
        logic [HALF_W-1:0] wdLow;
        logic [1:0] wmark;
    } mpb_req_type;

    typedef struct packed {
        logic [HALF_W-1:0] rdHigh;
        logic [HALF_W-1:0] rdLow;
        logic [1:0] rmark;
        logic [1:0] parErr;
        mpb_loc_type locClass;
    } mpb_rsp_type;

endpackage

/* File: hw/mpb_core_mem.sv */
// Core storage array with bit write mask and registered read data
`timescale 1ns/100ps
`default_nettype none
module mpb_core_mem #(
    parameter int DEPTH = mpb_pkg::SMALL_BANK_WORDS,
    parameter int WIDTH = mpb_pkg::WORD_W,
    parameter int AW = $clog2(DEPTH)
) (
    input wire logic sys_clk,
    input wire logic en,
    input wire logic [AW-1:0] addr,
    input wire logic [WIDTH-1:0] wdata,
    input wire logic [WIDTH-1:0] wmask,
    input wire logic we,
    output logic [WIDTH-1:0] rdata
);

    logic [WIDTH-1:0] mem [DEPTH];

    // Masked write keeps the untouched half and markers intact
    always_ff @(posedge sys_clk) begin
        if (en && we) begin
            for (int i = 0; i < WIDTH; i++) begin
                if (wmask[i]) begin
                    mem[addr][i] <= wdata[i];
                end
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (en) begin
            rdata <= mem[addr];
        end
    end

endmodule
`default_nettype wire

/* File: testbench/mpb_bank_ctrl_sva.sv */
// Port-level assertions for the bank control
`timescale 1ns/100ps
`default_nettype none
module mpb_bank_ctrl_sva #(
    parameter int BANK_WORDS = 8192,
    parameter logic [15:0] BANK_ID = 16'h0000,
    parameter int NUM_PORTS = 4
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [NUM_PORTS-1:0] portReqValid,
    input wire mpb_pkg::mpb_req_type [NUM_PORTS-1:0] portReq,
    input wire logic [NUM_PORTS-1:0] portAck,
    input wire logic [NUM_PORTS-1:0] portRspValid,
    input wire mpb_pkg::mpb_rsp_type portRsp,
    input wire logic hwRegStrobe,
    input wire logic parityClear,
    input wire logic parityIndicator,
    input wire logic parityIrq,
    input wire logic bankBusy
);
    logic [NUM_PORTS-1:0] selOk;
    logic [7:0] cycCnt_r;
    for (genvar i = 0; i < NUM_PORTS; i++) begin : g_sel
        assign selOk[i] = portReqValid[i] && ((portReq[i].addr >> $clog2(BANK_WORDS)) == BANK_ID);
    end
    // Cycles since the last grant; wraps harmlessly, only read when busy falls
    always_ff @(posedge sys_clk) begin
        cycCnt_r <= (sys_rst || (|portAck)) ? 8'h01 : cycCnt_r + 8'h01;
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    property p_ackOneHot;
        $onehot0(portAck);
    endproperty
    a_ackOneHot: assert property (p_ackOneHot) else $error("two ports granted at once");
    property p_ackCause;
        (portAck & ~selOk) == '0;
    endproperty
    a_ackCause: assert property (p_ackCause) else $error("grant without own-bank request");
    property p_prio;
        (|portAck) |-> ((portAck - 1'b1) & selOk) == '0;
    endproperty
    a_prio: assert property (p_prio) else $error("lower port passed over");
    property p_noAckBusy;
        bankBusy |-> portAck == '0;
    endproperty
    a_noAckBusy: assert property (p_noAckBusy) else $error("grant during storage cycle");
    property p_rspLat;
        (|portAck) |-> ##30 (portRspValid == $past(portAck, 30));
    endproperty
    a_rspLat: assert property (p_rspLat) else $error("response not 30 cycles after grant");
    property p_cycle;
        $fell(bankBusy) |-> cycCnt_r == 8'd80;
    endproperty
    a_cycle: assert property (p_cycle) else $error("storage cycle not 80 cycles");
    property p_irqRsp;
        parityIrq |-> (|portRspValid) && (|portRsp.parErr);
    endproperty
    a_irqRsp: assert property (p_irqRsp) else $error("parity event without failing read");
    property p_indHold;
        parityIndicator && !parityClear |=> parityIndicator;
    endproperty
    a_indHold: assert property (p_indHold) else $error("indicator dropped uncleared");
    property p_hwStrobe;
        hwRegStrobe |-> $past(portAck) != '0;
    endproperty
    a_hwStrobe: assert property (p_hwStrobe) else $error("register strobe without grant");
endmodule
`default_nettype wire

/* File: testbench/mpb_hwreg_model.sv */
// Hardware register set that answers the bank's register port
`timescale 1ns/100ps
`default_nettype none
module mpb_hwreg_model (
    input wire logic sys_clk,
    input wire logic hwRegStrobe,
    input wire logic hwRegWrite,
    input wire logic [4:0] hwRegAddr,
    input wire logic [1:0] hwRegHalfEn,
    input wire logic [31:0] hwRegWdata,
    output logic [31:0] hwRegRdata
);
    logic [31:0] regs [32];
    int holdCnt = 0;
    always @(posedge sys_clk) begin
        if (hwRegStrobe) begin
            holdCnt <= 30;
            if (hwRegWrite && hwRegHalfEn[0]) regs[hwRegAddr][15:0] <= hwRegWdata[15:0];
            if (hwRegWrite && hwRegHalfEn[1]) regs[hwRegAddr][31:16] <= hwRegWdata[31:16];
        end else if (holdCnt > 0) begin
            holdCnt <= holdCnt - 1;
        end
    end
    // Inverted outside the hold so a late sample cannot pass
    assign hwRegRdata = (hwRegStrobe || holdCnt > 0) ? regs[hwRegAddr] : ~regs[hwRegAddr];
endmodule
`default_nettype wire

/* File: testbench/test_multiport_memory_bank_control.sv */
// Self-checking bench for the bank control
`timescale 1ns/100ps
`default_nettype none
module test_multiport_memory_bank_control;
    logic sys_clk;
    logic sys_rst;
    logic [3:0] portReqValid;
    mpb_pkg::mpb_req_type [3:0] portReq;
    logic [3:0] portAck;
    logic [3:0] portRspValid;
    mpb_pkg::mpb_rsp_type portRsp;
    mpb_pkg::mpb_rsp_type rs;
    logic idxPresent;
    logic rafPresent;
    logic [8:0] extLinesInstalled;
    logic hwRegStrobe;
    logic hwRegWrite;
    logic [4:0] hwRegAddr;
    logic [1:0] hwRegHalfEn;
    logic [31:0] hwRegWdata;
    logic [31:0] hwRegRdata;
    logic parityClear;
    logic parityIndicator;
    logic parityIrq;
    logic bankBusy;
    int miscompares = 0;
    int n_checks = 0;

    mpb_bank_ctrl #(.BANK_WORDS(8192), .BANK_ID(16'h0000), .NUM_PORTS(4)) i_dut (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .portReqValid(portReqValid), .portReq(portReq),
        .portAck(portAck), .portRspValid(portRspValid), .portRsp(portRsp), .idxPresent(idxPresent),
        .rafPresent(rafPresent), .extLinesInstalled(extLinesInstalled), .hwRegStrobe(hwRegStrobe),
        .hwRegWrite(hwRegWrite), .hwRegAddr(hwRegAddr), .hwRegHalfEn(hwRegHalfEn), .hwRegWdata(hwRegWdata),
        .hwRegRdata(hwRegRdata), .parityClear(parityClear), .parityIndicator(parityIndicator),
        .parityIrq(parityIrq), .bankBusy(bankBusy));
    mpb_hwreg_model i_regs (
        .sys_clk(sys_clk), .hwRegStrobe(hwRegStrobe), .hwRegWrite(hwRegWrite), .hwRegAddr(hwRegAddr),
        .hwRegHalfEn(hwRegHalfEn), .hwRegWdata(hwRegWdata), .hwRegRdata(hwRegRdata));

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    task automatic check(input logic [35:0] got, input logic [35:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic complete_run;
        $display("Checks %0d, miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    function automatic mpb_pkg::mpb_req_type mkReq(input logic [3:0] op, input logic [15:0] a,
        input logic [31:0] d, input logic [1:0] m);
        mkReq = {op, a, d, m};
    endfunction

    // Op is {write, high, low, marker}; holds the request until granted
    task automatic access(input int p, input logic [3:0] op, input logic [15:0] a, input logic [31:0] d,
        input logic [1:0] m);
        int n;
        n = 0;
        portReq[p] <= mkReq(op, a, d, m);
        portReqValid[p] <= 1'b1;
        @(posedge sys_clk);
        while (portAck[p] !== 1'b1 && n < 200) begin
            @(posedge sys_clk);
            n++;
        end
        portReqValid[p] <= 1'b0;
        check(n < 200, 1'b1, "grant");
        repeat (29) @(posedge sys_clk);
        check(portRspValid[p], 1'b0, "early answer");
        @(posedge sys_clk);
        check(portRspValid[p], 1'b1, "answer");
        rs = portRsp;
    endtask

    task automatic s_dataPaths;
        access(1, 4'b1111, 16'h0100, 32'ha5c3_0f81, 2'b10);
        access(1, 4'b0111, 16'h0100, 32'h0, 2'b00);
        check({rs.rdHigh, rs.rdLow, rs.rmark, rs.parErr}, {32'ha5c3_0f81, 4'h8}, "full");
        access(2, 4'b1010, 16'h0100, 32'hffff_1234, 2'b00);
        access(2, 4'b0110, 16'h0100, 32'h0, 2'b00);
        check({rs.rdHigh, rs.rdLow, rs.rmark, rs.parErr}, {32'ha5c3_1234, 4'h0}, "low write");
        access(3, 4'b0100, 16'h0100, 32'h0, 2'b00);
        check({rs.rdHigh, rs.rdLow, rs.rmark}, {32'ha5c3_0000, 2'b00}, "high only");
        access(3, 4'b1001, 16'h0100, 32'h0, 2'b01);
        access(0, 4'b0001, 16'h0100, 32'h0, 2'b00);
        check({rs.rdHigh, rs.rdLow, rs.rmark, rs.locClass}, {32'h0, 2'b01, 2'h0}, "marker only");
        check({parityIndicator, parityIrq}, 2'b00, "no parity fault");
    endtask

    task automatic s_collide;
        int n;
        n = 0;
        portReq[2] <= mkReq(4'b0110, 16'h0100, 32'h0, 2'b00);
        portReq[3] <= mkReq(4'b0110, 16'h0100, 32'h0, 2'b00);
        portReqValid[3:2] <= 2'b11;
        @(posedge sys_clk);
        while (portAck === 4'h0 && n < 200) begin
            @(posedge sys_clk);
            n++;
        end
        check(portAck, 4'b0100, "first of pair");
        portReqValid[2] <= 1'b0;
        n = 0;
        @(posedge sys_clk);
        while (portAck[3] !== 1'b1 && n < 200) begin
            @(posedge sys_clk);
            n++;
        end
        portReqValid[3] <= 1'b0;
        check(n, 79, "pending spacing");
    endtask

    task automatic s_refuse;
        portReq[0] <= mkReq(4'b0110, 16'h2100, 32'h0, 2'b00);
        portReqValid[0] <= 1'b1;
        repeat (100) begin
            @(posedge sys_clk);
            check(portAck[0], 1'b0, "other bank");
        end
        portReqValid[0] <= 1'b0;
        @(posedge sys_clk);
        access(0, 4'b1110, 16'h1fff, 32'h0000_ffff, 2'b00);
        access(0, 4'b0110, 16'h1fff, 32'h0, 2'b00);
        check(rs.rdLow, 16'hffff, "top word");
    endtask

    // Reserved map with index absent, scratch-pad fitted, two external lines
    task automatic s_map;
        logic [15:0] adrs [8] = '{16'h0000, 16'h0001, 16'h0002, 16'h0017, 16'h0018, 16'h0030, 16'h0031, 16'h0033};
        logic [1:0] cls [8] = '{2'h1, 2'h1, 2'h0, 2'h1, 2'h0, 2'h2, 2'h3, 2'h0};
        for (int i = 0; i < 8; i++) begin
            access(0, 4'b1110, adrs[i], {~adrs[i], adrs[i]}, 2'b00);
            access(0, 4'b0110, adrs[i], 32'h0, 2'b00);
            check({rs.rdHigh, rs.rdLow, rs.locClass}, {~adrs[i], adrs[i], cls[i]}, "map");
        end
        idxPresent <= 1'b1;
        access(0, 4'b1110, 16'h0007, 32'h0007_7777, 2'b00);
        access(0, 4'b0110, 16'h0007, 32'h0, 2'b00);
        check({rs.rdLow, rs.locClass}, {16'h7777, 2'h1}, "index fitted");
        check({hwRegWrite, hwRegAddr}, {1'b0, 5'h07}, "register port");
    endtask

    initial begin
        sys_rst = 1'b1;
        portReqValid = 4'h0;
        portReq = '0;
        idxPresent = 1'b0;
        rafPresent = 1'b1;
        extLinesInstalled = 9'h002;
        parityClear = 1'b0;
        repeat (20) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        check({bankBusy, parityIndicator, portRspValid}, 36'h0, "after reset");
        s_dataPaths();
        s_collide();
        s_refuse();
        s_map();
        complete_run();
    end

    // Planned run is a few thousand cycles
    initial begin
        #(25 * 20000);
        miscompares++;
        complete_run();
    end
endmodule

bind mpb_bank_ctrl mpb_bank_ctrl_sva #(.BANK_WORDS(BANK_WORDS), .BANK_ID(BANK_ID), .NUM_PORTS(NUM_PORTS)) u_sva (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .portReqValid(portReqValid), .portReq(portReq), .portAck(portAck),
    .portRspValid(portRspValid), .portRsp(portRsp), .hwRegStrobe(hwRegStrobe), .parityClear(parityClear),
    .parityIndicator(parityIndicator), .parityIrq(parityIrq), .bankBusy(bankBusy));
`default_nettype wire
